// [mcu_instruction_timing_control_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module mcu_instruction_timing_control_tb;
  import mitc_pkg::*;
  logic              clock = 1'b0; // System clock
  logic              nrst  = 1'b0; // Reset, low
  logic [11:0]       pmem_addr;    // Fetch address
  logic [15:0]       pmem_rdata;   // Program word
  mitc_dmem_req_type dmem_req;     // Data access
  logic [7:0]        dmem_rdata;   // Data word
  logic [7:0]        acc;          // Accumulator
  mitc_flags_type    flags;        // Status flags
  logic              cycle_end;    // Cycle marker
  logic              int_enable;   // Interrupt exit seen
  int                n_errors  = 0;
  int                tests_run = 0;
  int                ce, clk_n, last;
  int                ce_at [256];  // Cycle count when each address was written
  logic [3:0]        op;
  logic [7:0]        a, b, t, x, y;
  logic [15:0]       w;
  logic [9:0]        e;
  logic [3:0]        ops [12] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_NOT,
                                  ALU_INC, ALU_SUB1, ALU_ROR, ALU_ROL, ALU_RORC, ALU_ROLC};
  // Call, a taken and an untaken skip test, interrupt exit, then a write to the PC low byte
  logic [27:0]       p2 [13] = '{28'h0003005, 28'h0018040, 28'h0022020, 28'h003300A,
                                 28'h0042006, 28'h0052022, 28'h00A2021, 28'h00B700B,
                                 28'h0403007, 28'h041D030, 28'h0423099, 28'h043D130,
                                 28'h0440200};

  always #50 clock = ~clock;

  mitc_core i_dut (.clock(clock), .nrst(nrst), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .acc(acc), .flags(flags),
    .int_enable(int_enable), .cycle_end(cycle_end));
  mitc_mem_model i_mem (.clock(clock), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

  // Expected {z, c, result}; flags start at zero after reset
  function automatic logic [9:0] exp_alu(input logic [3:0] o, input logic [7:0] p, q);
    logic [8:0] s;
    case (o)
      ALU_ADD: s = {1'b0, p} + {1'b0, q};
      ALU_SUB: s = {1'b0, p} - {1'b0, q};
      ALU_AND: s = {1'b0, p & q};
      ALU_OR:  s = {1'b0, p | q};
      ALU_XOR: s = {1'b0, p ^ q};
      ALU_NOT:  s = {1'b0, ~q};
      ALU_INC:  s = {1'b0, q + 8'h01};
      ALU_SUB1: s = {1'b0, q - 8'h01};
      ALU_ROR:  s = {1'b0, q[0], q[7:1]};
      ALU_ROL:  s = {1'b0, q[6:0], q[7]};
      ALU_RORC: s = {q[0], 1'b0, q[7:1]};
      default: s = {q[7], q[6:0], 1'b0};
    endcase
    return {(s[7:0] == 8'h00) && (o <= ALU_SUB1), s[8], s[7:0]};
  endfunction

  // Hold reset and clear both memories
  task automatic start();
    nrst = 1'b0;
    @(negedge clock);
    foreach (i_mem.rom[i]) i_mem.rom[i] = 16'h0000;
    foreach (i_mem.ram[i]) i_mem.ram[i] = 8'h00;
    foreach (ce_at[i]) ce_at[i] = -1;
  endtask

  // Finish the reset, then run and log strobes and cycle lengths
  task automatic go(input int n);
    repeat (9) @(negedge clock);
    nrst = 1'b1;
    ce = 0;
    clk_n = 0;
    repeat (n) begin
      @(negedge clock);
      clk_n++;
      if (dmem_req.we) ce_at[dmem_req.addr] = ce;
      if (cycle_end) begin
        if (ce > 0) `CHK("cycle length", 4, clk_n - last)
        last = clk_n;
        ce++;
      end
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(20000 * 100);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(78));
    // Every operation but ADC and SBC on a constant, corner carry and borrow first
    for (int i = 0; i < 24; i++) begin
      op = ops[i % 12];
      a = 8'($urandom);
      b = 8'($urandom);
      if (i < 2) begin
        a = (i == 0) ? 8'hFF : 8'h00;
        b = 8'h01;
      end
      start();
      i_mem.rom[0] = {CLS_MOVAI, 4'h0, a};
      i_mem.rom[1] = {CLS_ALUI, op, b};
      i_mem.rom[2] = {CLS_MOVMA, 4'h0, 8'h10};
      i_mem.rom[3] = {CLS_BRANCH, 12'h003};
      go(60);
      e = exp_alu(op, a, b);
      `CHK("stored result", e[7:0], i_mem.ram[16])
      `CHK("acc", e[7:0], acc)
      `CHK("z and c", e[9:8], {flags.z, flags.c})
    end
    $display("test operations done");
    // Control flow and its cycle costs
    start();
    foreach (p2[i]) i_mem.rom[p2[i][27:16]] = p2[i][15:0];
    go(100);
    `CHK("return value", 8'h07, i_mem.ram[8'h20])
    `CHK("cycles to store", 10, ce_at[8'h20])
    `CHK("pc low branch", 8'h0A, i_mem.ram[8'h21])
    `CHK("pc low cycles", 14, ce_at[8'h21])
    `CHK("dropped word", 8'h00, i_mem.ram[8'h22])
    `CHK("interrupt exit", 1'b1, int_enable)
    $display("test control flow done");
    // Bit set/clear, in-place increment, table read
    start();
    t = 8'($urandom);
    x = 8'($urandom);
    y = 8'($urandom);
    w = 16'($urandom);
    i_mem.rom[{4'hF, t}] = w;
    i_mem.ram[8'h50] = x;
    i_mem.ram[8'h51] = y;
    i_mem.rom[0] = {CLS_MOVAI, 4'h0, t};
    i_mem.rom[1] = 16'hB350;
    i_mem.rom[2] = 16'hC550;
    i_mem.rom[3] = 16'h5851;
    i_mem.rom[4] = 16'hE052;
    i_mem.rom[5] = 16'h7005;
    go(80);
    `CHK("bit ops", (x | 8'h08) & 8'hDF, i_mem.ram[8'h50])
    `CHK("inc in place", y + 8'h01, i_mem.ram[8'h51])
    `CHK("acc kept", t, acc)
    `CHK("table byte", w[7:0], i_mem.ram[8'h52])
    $display("test bit and table done");
    wrap_up();
  end
endmodule

// [mitc_alu.sv]
`timescale 1ns/1ps

module mitc_alu (
  input  wire logic [3:0]               op,     // Operation code
  input  wire logic [7:0]               a,      // Accumulator
  input  wire logic [7:0]               b,      // Second operand
  input  wire logic                     cin,    // Current carry flag
  output logic [7:0]                    result, // Operation result
  output mitc_pkg::mitc_flags_type      flg,    // New flag values
  output mitc_pkg::mitc_flags_type      upd     // Flags this op may change
);
  import mitc_pkg::*;

  // ----------------------------------------
  // Adder and subtractor
  // ----------------------------------------
  logic       cy_in; // Carry or borrow taken in
  logic [8:0] sum9;  // Sum with carry out
  logic [4:0] sum4;  // Low nibble sum
  logic [8:0] dif9;  // Difference with borrow out
  logic [4:0] dif4;  // Low nibble difference

  assign cy_in = (op == ALU_ADC || op == ALU_SBC) ? cin : 1'b0;
  assign sum9  = {1'b0, a} + {1'b0, b} + {8'h00, cy_in};
  assign sum4  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy_in};
  assign dif9  = {1'b0, a} - {1'b0, b} - {8'h00, cy_in};
  assign dif4  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy_in};

  // Result and flag select; zero comes from the result for every op
  always_comb begin
    result = b;
    flg    = '0;
    upd    = '0;
    case (op)
      // Carry out beyond 255 kept for multi-byte sums
      ALU_ADD, ALU_ADC: begin
        result = sum9[7:0];
        flg.c  = sum9[8];
        flg.hc = sum4[4];
        flg.vf = (a[7] == b[7]) && (sum9[7] != a[7]);
        upd    = '1;
      end
      // Borrow set when the difference drops below 0
      ALU_SUB, ALU_SBC: begin
        result = dif9[7:0];
        flg.c  = dif9[8];
        flg.hc = dif4[4];
        flg.vf = (a[7] != b[7]) && (dif9[7] != a[7]);
        upd    = '1;
      end
      ALU_AND: begin
        result = a & b;
        upd.z  = 1'b1;
      end
      ALU_OR: begin
        result = a | b;
        upd.z  = 1'b1;
      end
      ALU_XOR: begin
        result = a ^ b;
        upd.z  = 1'b1;
      end
      ALU_NOT: begin
        result = ~b;
        upd.z  = 1'b1;
      end
      ALU_INC: begin
        result = b + 8'h01;
        upd.z  = 1'b1;
      end
      ALU_SUB1: begin
        result = b - 8'h01;
        upd.z  = 1'b1;
      end
      // rotate by one
      // Plain rotates touch no flag
      ALU_ROR: result = {b[0], b[7:1]};
      ALU_ROL: result = {b[6:0], b[7]};
      // Through-carry: old carry fills the gap, bit out goes to carry
      ALU_RORC: begin
        result = {cin, b[7:1]};
        flg.c  = b[0];
        upd.c  = 1'b1;
      end
      ALU_ROLC: begin
        result = {b[6:0], cin};
        flg.c  = b[7];
        upd.c  = 1'b1;
      end
      default: result = b;
    endcase
    flg.z = (result == 8'h00);
  end

endmodule

// [mitc_core.sv]
`timescale 1ns/1ps

// How it works
// - Instruction cycle is four system clocks
// - Branches, calls, exits, table reads take two
// - Writing PC low byte branches, takes two
// - Taken skip costs one extra cycle
// - Moves: memory/accumulator both ways, constant
// - Carry above 255, borrow below zero
// - Increment/decrement by one, in place or accumulator
// - Logic ops via accumulator set zero flag
// - Rotates by one, carry variants through carry
// - Call saves next address, exit resumes there
// - Jump loads target, saves nothing
// - Conditional tests skip next instruction
// - Arithmetic sets four flags, carry rotates carry only, plain rotates none, others zero only
// - Bit set/clear keeps other bits
module mitc_core #(
  parameter int unsigned STACK_DEPTH = 8 // Return address levels
) (
  input  wire logic                     clock,      // System clock
  input  wire logic                     nrst,       // Sync reset, low
  output logic [mitc_pkg::PC_W-1:0]     pmem_addr,  // Program address
  input  wire logic [15:0]              pmem_rdata, // Program word
  output mitc_pkg::mitc_dmem_req_type   dmem_req,   // Data memory access
  input  wire logic [7:0]               dmem_rdata, // Data memory word
  output logic [7:0]                    acc,        // Accumulator
  output mitc_pkg::mitc_flags_type      flags,      // Status flags
  output logic                          int_enable, // Set by interrupt exit
  output logic                          cycle_end   // Last clock of a cycle
);
  import mitc_pkg::*;

  localparam int unsigned SP_W = $clog2(STACK_DEPTH); // Stack pointer width

  // ----------------------------------------
  // State
  // ----------------------------------------
  mitc_phase_type    phase_reg;       // Clock within the cycle
  mitc_phase_type    phase_next;      // Next phase
  logic [PC_W-1:0]   pc_reg;          // Address being prefetched
  logic [PC_W-1:0]   ir_pc_reg;       // Address of executing word
  logic [PC_W-1:0]   pmem_addr_reg;   // Registered fetch address
  logic [15:0]       ir_reg;          // Executing word
  logic              flush_reg;       // Current word is discarded
  logic              jump_reg;        // Redirect at end of cycle
  logic [PC_W-1:0]   target_reg;      // Redirect address
  logic [7:0]        acc_reg;         // Accumulator
  mitc_flags_type    flags_reg;       // Flags
  logic              int_en_reg;      // Interrupt enable
  logic [7:0]        dmem_addr_reg;   // Data address
  logic [7:0]        dmem_wdata_reg;  // Data write value
  logic              dmem_we_reg;     // Data write strobe
  logic [SP_W-1:0]   sp_reg;          // Stack pointer
  logic [PC_W-1:0]   stack_mem [STACK_DEPTH]; // Return addresses

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [3:0]        cls;       // Class field
  logic [3:0]        sub;       // Op or bit field
  logic [7:0]        opnd;      // Address or constant
  logic [11:0]       addr12;    // Branch target field
  logic [7:0]        bit_mask;  // One-hot bit select
  logic              at_ph0;    // Phase flags
  logic              at_ph2;
  logic              at_ph3;
  logic              exec_en;   // Word is live
  logic              commit;    // Results land this edge
  logic              is_imm;    // Constant operand
  logic              is_branch;
  logic              is_call;
  logic              is_exit;
  logic              is_tbl;
  logic              alu_cls;   // Uses the operation unit
  logic              wr_acc;    // Writes accumulator
  logic              wr_mem;    // Writes data memory
  logic              pc_lo_hit; // Destination is PC low byte
  logic              skip_take; // Test says skip
  logic              flow;      // Redirect needed
  logic [7:0]        mem_val;   // Memory operand
  logic [7:0]        src_b;     // Second operand
  logic [7:0]        alu_res;   // Unit result
  logic [7:0]        acc_wval;  // Accumulator write value
  logic [7:0]        mem_wval;  // Memory write value
  logic [PC_W-1:0]   ret_addr;  // Top of stack
  logic [PC_W-1:0]   target;    // Redirect address
  mitc_flags_type    alu_flg;   // Unit flag values
  mitc_flags_type    alu_upd;   // Unit flag mask
  mitc_flags_type    flags_nv;  // Merged flags

  assign cls      = ir_reg[15:12];
  assign sub      = ir_reg[11:8];
  assign opnd     = ir_reg[7:0];
  assign addr12   = ir_reg[11:0];
  assign bit_mask = 8'h01 << sub[2:0];
  assign at_ph0   = (phase_reg == PH0);
  assign at_ph2   = (phase_reg == PH2);
  assign at_ph3   = (phase_reg == PH3);
  assign exec_en  = !flush_reg;
  assign commit   = at_ph2 && exec_en;

  assign is_imm  = (cls == CLS_MOVAI) || (cls == CLS_ALUI);
  assign is_branch = (cls == CLS_BRANCH);
  assign is_call = (cls == CLS_CALL);
  assign is_exit = (cls == CLS_MISC) && (sub == SUB_EXIT || sub == SUB_IEXIT);
  assign is_tbl  = (cls == CLS_TBLRD);
  assign alu_cls = cls inside {CLS_ALUA, CLS_ALUM, CLS_ALUI};
  assign wr_acc  = cls inside {CLS_MOVAM, CLS_MOVAI, CLS_ALUA, CLS_ALUI};
  assign wr_mem  = cls inside {CLS_MOVMA, CLS_ALUM, CLS_BSET, CLS_BCLR, CLS_TBLRD};
  assign pc_lo_hit = wr_mem && (opnd == PC_LO_ADDR);

  // PC low byte reads as the executing word's address
  assign mem_val  = (opnd == PC_LO_ADDR) ? ir_pc_reg[7:0] : dmem_rdata;
  assign src_b    = is_imm ? opnd : mem_val;
  assign acc_wval = alu_cls ? alu_res : src_b;
  assign mem_wval = (cls == CLS_MOVMA) ? acc_reg :
                    (cls == CLS_ALUM)  ? alu_res :
                    (cls == CLS_BSET)  ? (mem_val | bit_mask) :
                    (cls == CLS_BCLR)  ? (mem_val & ~bit_mask) :
                    pmem_rdata[7:0];

  assign skip_take = ((cls == CLS_SKBC) && !mem_val[sub[2:0]]) ||
                     ((cls == CLS_SKBS) && mem_val[sub[2:0]]) ||
                     ((cls == CLS_SKZ) && ((mem_val == 8'h00) ^ sub[0]));

  assign ret_addr = stack_mem[sp_reg - 1'b1];
  assign flow     = is_branch || is_call || is_exit || pc_lo_hit || skip_take || is_tbl;
  assign target = (is_branch || is_call) ? addr12 :
                  is_exit                ? ret_addr :
                  pc_lo_hit              ? {ir_pc_reg[11:8], mem_wval} :
                  is_tbl              ? pc_reg :
                  pc_reg + 12'h001;

  // only the flags the op owns change
  assign flags_nv = mitc_flags_type'((flags_reg & ~alu_upd) | (alu_flg & alu_upd));

  // carry and borrow from the unit
  mitc_alu u_alu (
    .op     (sub),
    .a      (acc_reg),
    .b      (src_b),
    .cin    (flags_reg.c),
    .result (alu_res),
    .flg    (alu_flg),
    .upd    (alu_upd)
  );

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  // four clocks per cycle
  always_comb begin
    phase_next = PH0;
    unique case (phase_reg)
      PH0: phase_next = PH1;
      PH1: phase_next = PH2;
      PH2: phase_next = PH3;
      PH3: phase_next = PH0;
    endcase
  end

  // Phase register
  always_ff @(posedge clock) begin
    if (!nrst) phase_reg <= PH0;
    else       phase_reg <= phase_next;
  end

  // ----------------------------------------
  // Fetch and program counter
  // ----------------------------------------
  // Table read borrows the fetch slot, so the prefetch is redone
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pmem_addr_reg <= PC_RESET;
    end else if (at_ph0) begin
      pmem_addr_reg <= (exec_en && is_tbl) ? {TBL_PAGE, acc_reg} : pc_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_reg    <= PC_RESET;
      ir_pc_reg <= PC_RESET;
      ir_reg    <= IR_RESET;
      flush_reg <= 1'b1;
    end else if (at_ph3) begin
      if (jump_reg) begin
        pc_reg    <= target_reg;
        flush_reg <= 1'b1;
      end else begin
        ir_reg    <= pmem_rdata;
        ir_pc_reg <= pc_reg;
        pc_reg    <= pc_reg + 12'h001;
        flush_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      jump_reg   <= 1'b0;
      target_reg <= PC_RESET;
    end else if (at_ph2) begin
      jump_reg   <= exec_en && flow;
      target_reg <= target;
    end
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  // accumulator and flag write-back
  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc_reg    <= ACC_RESET;
      flags_reg  <= '0;
      int_en_reg <= 1'b0;
    end else if (commit) begin
      if (wr_acc)  acc_reg   <= acc_wval;
      if (alu_cls) flags_reg <= flags_nv;
      if (is_exit && sub == SUB_IEXIT) int_en_reg <= 1'b1;
    end
  end

  // Write strobe spans the last clock; PC byte writes skip memory
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dmem_we_reg    <= 1'b0;
      dmem_wdata_reg <= 8'h00;
      dmem_addr_reg  <= 8'h00;
    end else begin
      if (commit) begin
        dmem_we_reg    <= wr_mem && !pc_lo_hit;
        dmem_wdata_reg <= mem_wval;
      end else if (at_ph3) begin
        dmem_we_reg    <= 1'b0;
      end
      if (at_ph3) dmem_addr_reg <= pmem_rdata[7:0];
    end
  end

  // push on call, pop on exit
  always_ff @(posedge clock) begin
    if (!nrst)                  sp_reg <= '0;
    else if (commit && is_call) sp_reg <= sp_reg + 1'b1;
    else if (commit && is_exit) sp_reg <= sp_reg - 1'b1;
  end

  // Stack wraps on overflow; deeper nesting overwrites oldest
  always_ff @(posedge clock) begin
    if (commit && is_call) stack_mem[sp_reg] <= pc_reg;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pmem_addr  = pmem_addr_reg;
  assign dmem_req   = '{addr: dmem_addr_reg, wdata: dmem_wdata_reg, we: dmem_we_reg};
  assign acc        = acc_reg;
  assign flags      = flags_reg;
  assign int_enable = int_en_reg;
  assign cycle_end  = at_ph3;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_single;
    ##2 !flush_reg ##0 (pc_reg == $past(pc_reg, 2) + 12'h001);
  endsequence

  property p_redirect(cond);
    logic [PC_W-1:0] t;
    (commit && cond, t = target) |-> ##2 (flush_reg && pc_reg == t) ##4 !flush_reg;
  endproperty

  a_cycle_four: assert property (
    at_ph0 |=> (phase_reg == PH1) ##1 at_ph2 ##1 at_ph3 ##1 at_ph0)
    else $error("instruction cycle is not four clocks");
  a_plain_single: assert property (
    (commit && !flow) |-> s_single)
    else $error("plain instruction took extra cycle");
  a_jump_redirect: assert property (p_redirect(is_branch))
    else $error("jump did not redirect in two cycles");
  a_pc_lo_branch: assert property (p_redirect(pc_lo_hit))
    else $error("PC low byte write did not branch");
  a_skip_taken: assert property (p_redirect(skip_take))
    else $error("taken skip did not drop next word");
  a_call_saves: assert property (
    (commit && is_call) |-> ##1 (stack_mem[sp_reg - 1'b1] == $past(pc_reg)))
    else $error("call saved wrong return address");
  a_add_carry: assert property (
    (commit && alu_cls && cls != CLS_ALUM && sub == ALU_ADD) |->
      ##1 ({flags_reg.c, acc_reg} == $past({1'b0, acc_reg} + {1'b0, src_b})))
    else $error("add result or carry wrong");
  a_logic_zero: assert property (
    (commit && alu_cls && sub == ALU_AND) |->
      ##1 (flags_reg.z == (((cls == CLS_ALUM) ? dmem_req.wdata : acc_reg) == 8'h00))
          && $stable(flags_reg.c) && $stable(flags_reg.vf))
    else $error("logic op flags wrong");
  a_inc_one: assert property (
    (commit && cls == CLS_ALUM && sub == ALU_INC && !pc_lo_hit) |->
      ##1 dmem_req.we && (dmem_req.wdata == $past(mem_val) + 8'h01))
    else $error("in-place increment wrong");
  property p_rotate;
    logic [7:0] v;
    logic c0;
    (commit && alu_cls && cls != CLS_ALUM && sub == ALU_ROLC, v = src_b, c0 = flags_reg.c)
      |-> ##1 (acc_reg == {v[6:0], c0}) && (flags_reg.c == v[7]);
  endproperty
  a_rotate_carry: assert property (p_rotate)
    else $error("rotate through carry wrong");
  property p_bitset;
    logic [7:0] v;
    logic [7:0] m;
    (commit && cls == CLS_BSET && !pc_lo_hit, v = mem_val, m = bit_mask)
      |-> ##1 (dmem_req.we && dmem_req.wdata == (v | m)) ##1 !dmem_req.we;
  endproperty
  a_bit_set: assert property (p_bitset)
    else $error("bit set changed other bits");
  a_move_store: assert property (
    (commit && cls == CLS_MOVMA && !pc_lo_hit) |->
      ##1 dmem_req.we && (dmem_req.wdata == $past(acc_reg)))
    else $error("store of accumulator wrong");
  a_arith_flags: assert property (
    (commit && alu_cls && cls != CLS_ALUM && sub == ALU_SUB) |->
      ##1 (flags_reg.c == ($past(src_b) > $past(acc_reg))) && (flags_reg.z == (acc_reg == 8'h00)))
    else $error("subtract borrow or zero wrong");
  a_flush_idle: assert property (
    (at_ph2 && flush_reg) |-> ##1 $stable(acc_reg) && !dmem_req.we && !jump_reg)
    else $error("discarded word had an effect");

endmodule

// [mitc_mem_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Program and data memory behind the core
// ----------------------------------------
// Reads answer combinationally; the bench preloads both arrays
module mitc_mem_model (
  input  wire logic                        clock,      // System clock
  input  wire logic [11:0]                 pmem_addr,  // Fetch address
  output logic [15:0]                      pmem_rdata, // Program word
  input  wire mitc_pkg::mitc_dmem_req_type dmem_req,   // Data access
  output logic [7:0]                       dmem_rdata  // Data word
);
  import mitc_pkg::*;
  logic [15:0] rom [4096]; // Program words
  logic [7:0]  ram [256];  // Data bytes
  // Answer in the same clock, sooner than the core needs
  assign pmem_rdata = rom[pmem_addr];
  assign dmem_rdata = ram[dmem_req.addr];
  // Store at the edge that ends the strobe
  always @(posedge clock) begin
    if (dmem_req.we) begin
      ram[dmem_req.addr] <= dmem_req.wdata;
    end
  end
endmodule

// [mitc_pkg.sv]
package mitc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ     = 10_000_000; // System clock rate
  localparam int unsigned INSTR_CLKS = 4;          // Clocks per instruction cycle

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned PC_W      = 12;      // 4096-word program space
  localparam logic [11:0] PC_RESET  = 12'h000; // Reset vector
  localparam logic [7:0]  ACC_RESET = 8'h00;   // Accumulator after reset
  localparam logic [15:0] IR_RESET  = 16'h0000; // Reads as a no-op
  localparam logic [7:0]  PC_LO_ADDR = 8'h06;  // Data address of the PC low byte
  localparam logic [3:0]  TBL_PAGE  = 4'hF;    // Program page used by table reads

  // ----------------------------------------
  // Instruction classes, word bits [15:12]
  // ----------------------------------------
  localparam logic [3:0] CLS_MISC  = 4'h0; // Sub: no-op, exits
  localparam logic [3:0] CLS_MOVAM = 4'h1; // Memory to accumulator
  localparam logic [3:0] CLS_MOVMA = 4'h2; // Accumulator to memory
  localparam logic [3:0] CLS_MOVAI = 4'h3; // Constant to accumulator
  localparam logic [3:0] CLS_ALUA  = 4'h4; // Operation, result to accumulator
  localparam logic [3:0] CLS_ALUM  = 4'h5; // Operation, result in place
  localparam logic [3:0] CLS_ALUI  = 4'h6; // Operation with constant
  localparam logic [3:0] CLS_BRANCH = 4'h7; // Unconditional branch
  localparam logic [3:0] CLS_CALL  = 4'h8; // Subroutine call
  localparam logic [3:0] CLS_SKBC  = 4'h9; // Skip if bit clear
  localparam logic [3:0] CLS_SKBS  = 4'hA; // Skip if bit set
  localparam logic [3:0] CLS_BSET  = 4'hB; // Set one bit
  localparam logic [3:0] CLS_BCLR  = 4'hC; // Clear one bit
  localparam logic [3:0] CLS_SKZ   = 4'hD; // Skip on zero / non-zero
  localparam logic [3:0] CLS_TBLRD = 4'hE; // Table read into memory

  localparam logic [3:0] SUB_NOP  = 4'h0; // No operation
  localparam logic [3:0] SUB_EXIT  = 4'h1; // Subroutine exit
  localparam logic [3:0] SUB_IEXIT = 4'h2; // Interrupt exit

  // ----------------------------------------
  // Operation codes, word bits [11:8]
  // ----------------------------------------
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_ADC = 4'h1;
  localparam logic [3:0] ALU_SUB = 4'h2;
  localparam logic [3:0] ALU_SBC = 4'h3;
  localparam logic [3:0] ALU_AND = 4'h4;
  localparam logic [3:0] ALU_OR  = 4'h5;
  localparam logic [3:0] ALU_XOR = 4'h6;
  localparam logic [3:0] ALU_NOT  = 4'h7;
  localparam logic [3:0] ALU_INC  = 4'h8;
  localparam logic [3:0] ALU_SUB1 = 4'h9;
  localparam logic [3:0] ALU_ROR  = 4'hA;
  localparam logic [3:0] ALU_ROL  = 4'hB;
  localparam logic [3:0] ALU_RORC = 4'hC;
  localparam logic [3:0] ALU_ROLC = 4'hD;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    PH0 = 4'b0001,
    PH1 = 4'b0010,
    PH2 = 4'b0100,
    PH3 = 4'b1000
  } mitc_phase_type;

  typedef struct packed {
    logic z;  // Zero
    logic c;  // Carry, or borrow after subtract
    logic hc; // Auxiliary carry from bit 3
    logic vf; // Signed overflow
  } mitc_flags_type;

  typedef struct packed {
    logic [7:0] addr;  // Data address
    logic [7:0] wdata; // Write data
    logic       we;    // Write strobe
  } mitc_dmem_req_type;

endpackage
